// ==== cdip_cfg.svh ====
/*
 * Constants of the codec decimate/interpolate path: register offsets,
 * field positions, reset values and arithmetic limits.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef CDIP_CFG_SVH
`define CDIP_CFG_SVH

// Register byte offsets on the AHB-Lite slave
`define CDIP_OFS_RATE 8'h00
`define CDIP_OFS_GAIN 8'h04
`define CDIP_OFS_FILT 8'h08
`define CDIP_OFS_DAC 8'h0C
`define CDIP_OFS_ADC 8'h10
`define CDIP_OFS_STAT 8'h14

// Field positions inside filter_control_reg
`define CDIP_FILT_BYP 5
`define CDIP_FILT_MIX 0

// Reset values
`define CDIP_RATE_RST 2'h0
`define CDIP_GAIN_RST 3'h0

// Clock ladder: external clock divider last count, bit-rate divider last count
`define CDIP_MCLK_LAST 3'h0
`define CDIP_BIT_LAST 3'h7

// Encoder gain in dB per select code
`define CDIP_DB0 6'h00
`define CDIP_DB1 6'h06
`define CDIP_DB2 6'h0C
`define CDIP_DB3 6'h12
`define CDIP_DB4 6'h14
`define CDIP_DB5 6'h1A
`define CDIP_DB6 6'h20
`define CDIP_DB7 6'h26

// Datapath limits
`define CDIP_SAT_POS 25'h0800000
`define CDIP_FS_POS 16'h7FFF
`define CDIP_DATA_FLAG 1'b0
`define CDIP_DSM_FBP 18'h07FFF
`define CDIP_DSM_FBN 18'h38000
`define CDIP_WORD_TOP 5'h18

`endif

// ==== cdip_pkg.sv ====
/*
 * Types of the codec decimate/interpolate path.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cdip_pkg;
    // Sample rate codes held in rate_control_reg
    typedef enum logic [1:0] {
        CDIP_R64K = 2'h0,
        CDIP_R32K = 2'h1,
        CDIP_R16K = 2'h2,
        CDIP_R8K = 2'h3
    } cdip_rate_t;
endpackage

// ==== cdip_comb_if.sv ====
/*
 * Carrier between the path and one triple comb section.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface cdip_comb_if #(parameter int W = 16);
    logic en;
    logic [W-1:0] din;
    logic [W-1:0] dout;
    modport host(output en, output din, input dout);
    modport comb(input en, input din, output dout);
endinterface
`default_nettype wire

// ==== cdip_comb3.sv ====
/*
 * Three cascaded differentiators (1 - z^-1)^3, stepping on en.
 * Assumes wrap-around arithmetic is wanted: in the decimator the integrators feeding it wrap too.
 */
`timescale 1ns/100ps
`default_nettype none
module cdip_comb3 (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Comb port
    cdip_comb_if.comb cb
);
    localparam int W = $bits(cb.din);
    logic [W-1:0] d0_r, d1_r, d2_r, y_r;
    logic [W-1:0] s1, s2, s3;

    // Differences; modular, so no growth is needed
    assign s1 = cb.din - d0_r;
    assign s2 = s1 - d1_r;
    assign s3 = s2 - d2_r;

    // Delay line and output, one step per enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            d0_r <= '0;
            d1_r <= '0;
            d2_r <= '0;
            y_r <= '0;
        end else if (cb.en) begin
            d0_r <= cb.din;
            d1_r <= s1;
            d2_r <= s2;
            y_r <= s3;
        end
    end
    assign cb.dout = y_r;
endmodule
`default_nettype wire

// ==== cdip_path.sv ====
/*
 * Digital datapath of one codec channel pair: gain select, sinc3
 * decimator, ADC word formatting, sinc3 interpolator with bypass and
 * a first-order digital sigma-delta modulator, behind AHB-Lite.
 * Assumes modBitPin comes from the analog modulator, asynchronous to
 * sys_clk, and changes no faster than the bit rate.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cdip_cfg.svh"
module cdip_path
    import cdip_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Encoder gain
    output logic [2:0] gainSel,
    output logic [5:0] gainDb,
    // ADC modulator bit from the pin
    input wire logic modBitPin,
    // ADC words
    output logic [15:0] adcWord,
    output logic adcStrobe,
    // DAC bit stream
    output logic dacBit,
    output logic bitStrobe
);
    ////////////////////////////////////////////////////////////////////
    // Bus slave
    logic wr_r, rd_r;
    logic [7:0] addr_r;
    logic addrPhase, wrEn;
    cdip_rate_t rateSel_r;
    logic [2:0] gainSel_r;
    logic bypass_r, mixed_r, pend_r;
    logic [15:0] dacIn_r;
    logic [15:0] adcWord_r;
    logic [31:0] rdMux;

    // Whole-word single transfers only, so hsize is not decoded
    assign addrPhase = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wrEn = wr_r;

    // Address phase capture
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 8'h00;
        end else if (hready) begin
            wr_r <= addrPhase && hwrite;
            rd_r <= addrPhase && !hwrite;
            addr_r <= haddr[7:0];
        end
    end

    // Control registers written in the data phase
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rateSel_r <= cdip_rate_t'(`CDIP_RATE_RST);
            gainSel_r <= `CDIP_GAIN_RST;
            bypass_r <= 1'b0;
            mixed_r <= 1'b0;
        end else if (wrEn) begin
            if (addr_r == `CDIP_OFS_RATE) begin
                rateSel_r <= cdip_rate_t'(hwdata[1:0]);
            end else if (addr_r == `CDIP_OFS_GAIN) begin
                gainSel_r <= hwdata[2:0];
            end else if (addr_r == `CDIP_OFS_FILT) begin
                bypass_r <= hwdata[`CDIP_FILT_BYP];
                mixed_r <= hwdata[`CDIP_FILT_MIX];
            end
        end
    end

    // Read mux over flops; unmapped offsets read zero
    always_comb begin
        rdMux = 32'h0000_0000;
        if (addr_r == `CDIP_OFS_RATE) begin
            rdMux[1:0] = rateSel_r;
        end else if (addr_r == `CDIP_OFS_GAIN) begin
            rdMux[2:0] = gainSel_r;
        end else if (addr_r == `CDIP_OFS_FILT) begin
            rdMux[`CDIP_FILT_BYP] = bypass_r;
            rdMux[`CDIP_FILT_MIX] = mixed_r;
        end else if (addr_r == `CDIP_OFS_DAC) begin
            rdMux[15:0] = dacIn_r;
        end else if (addr_r == `CDIP_OFS_ADC) begin
            rdMux[15:0] = adcWord_r;
        end else if (addr_r == `CDIP_OFS_STAT) begin
            rdMux[0] = pend_r;
        end
    end
    assign hrdata = rd_r ? rdMux : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // Gain select
    logic [5:0] gainDb_r;

    // Code to dB table, registered so the pins never glitch
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gainDb_r <= `CDIP_DB0;
        end else begin
            case (gainSel_r)
                3'h0: gainDb_r <= `CDIP_DB0;
                3'h1: gainDb_r <= `CDIP_DB1;
                3'h2: gainDb_r <= `CDIP_DB2;
                3'h3: gainDb_r <= `CDIP_DB3;
                3'h4: gainDb_r <= `CDIP_DB4;
                3'h5: gainDb_r <= `CDIP_DB5;
                3'h6: gainDb_r <= `CDIP_DB6;
                default: gainDb_r <= `CDIP_DB7;
            endcase
        end
    end
    assign gainSel = gainSel_r;
    assign gainDb = gainDb_r;

    ////////////////////////////////////////////////////////////////////
    // Clock ladder
    logic [2:0] mclkCnt_r, bitCnt_r;
    logic [7:0] osrCnt_r, nLast;
    logic [4:0] k3, k2;
    logic dmclkEn, bitEn, sampleTick;

    // Filter length per rate, as powers of two
    always_comb begin
        case (rateSel_r)
            CDIP_R64K: begin
                nLast = 8'h1F;
                k3 = 5'h0F;
                k2 = 5'h0A;
            end
            CDIP_R32K: begin
                nLast = 8'h3F;
                k3 = 5'h12;
                k2 = 5'h0C;
            end
            CDIP_R16K: begin
                nLast = 8'h7F;
                k3 = 5'h15;
                k2 = 5'h0E;
            end
            default: begin
                nLast = 8'hFF;
                k3 = 5'h18;
                k2 = 5'h10;
            end
        endcase
    end

    // Internal master clock enable from the input clock divider
    always_ff @(posedge sys_clk) begin
        if (!rst_n || mclkCnt_r == `CDIP_MCLK_LAST) begin
            mclkCnt_r <= 3'h0;
        end else begin
            mclkCnt_r <= mclkCnt_r + 3'h1;
        end
    end
    assign dmclkEn = (mclkCnt_r == `CDIP_MCLK_LAST);

    // Bit rate is internal clock over eight
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bitCnt_r <= 3'h0;
        end else if (dmclkEn) begin
            bitCnt_r <= bitCnt_r + 3'h1;
        end
    end
    assign bitEn = dmclkEn && (bitCnt_r == `CDIP_BIT_LAST);

    // Oversampling count; >= guards a shrink of N mid-period
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            osrCnt_r <= 8'h00;
        end else if (bitEn) begin
            osrCnt_r <= (osrCnt_r >= nLast) ? 8'h00 : osrCnt_r + 8'h01;
        end
    end
    assign sampleTick = bitEn && (osrCnt_r >= nLast);
    assign bitStrobe = bitEn;

    ////////////////////////////////////////////////////////////////////
    // Decimator
    logic syncA_r, syncB_r;
    logic [24:0] di1_r, di2_r, di3_r;
    logic [24:0] sgnv, aligned, half;
    logic [15:0] trunc, fmt;
    logic decRdy_r, adcStrobe_r;
    cdip_comb_if #(.W(25)) decIf ();

    // Pin synchroniser
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            syncA_r <= 1'b0;
            syncB_r <= 1'b0;
        end else begin
            syncA_r <= modBitPin;
            syncB_r <= syncA_r;
        end
    end

    // Integrators at the bit rate; wrap is harmless ahead of the combs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            di1_r <= '0;
            di2_r <= '0;
            di3_r <= '0;
        end else if (bitEn) begin
            di1_r <= di1_r + {24'h000000, syncB_r};
            di2_r <= di2_r + di1_r;
            di3_r <= di3_r + di2_r;
        end
    end

    assign decIf.en = sampleTick;
    assign decIf.din = di3_r;
    cdip_comb3 u_decComb (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cb(decIf)
    );

    // Unsigned 0..N^3 to centred twos complement, MSB-aligned at bit 23
    assign half = 25'h0000001 << (k3 - 5'h01);
    assign sgnv = decIf.dout - half;
    assign aligned = sgnv << (`CDIP_WORD_TOP - k3);
    always_comb begin
        if (aligned == `CDIP_SAT_POS) begin
            trunc = `CDIP_FS_POS;
        end else begin
            trunc = aligned[23:8];
        end
        if (rateSel_r == CDIP_R64K) begin
            trunc[1:0] = 2'h0;
        end
        fmt = mixed_r ? {`CDIP_DATA_FLAG, trunc[15:1]} : trunc;
    end

    // Comb output settles one cycle after the tick
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            decRdy_r <= 1'b0;
            adcStrobe_r <= 1'b0;
            adcWord_r <= 16'h0000;
        end else begin
            decRdy_r <= sampleTick;
            adcStrobe_r <= decRdy_r;
            if (decRdy_r) begin
                adcWord_r <= fmt;
            end
        end
    end
    assign adcWord = adcWord_r;
    assign adcStrobe = adcStrobe_r;

    ////////////////////////////////////////////////////////////////////
    // DAC sample hold
    logic [15:0] dacHeld_r;

    // Host write and pending flag; a write in the tick cycle wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dacIn_r <= 16'h0000;
            pend_r <= 1'b0;
        end else if (wrEn && addr_r == `CDIP_OFS_DAC) begin
            dacIn_r <= hwdata[15:0];
            pend_r <= 1'b1;
        end else if (sampleTick) begin
            pend_r <= 1'b0;
        end
    end

    // Latest value taken each period; with no write it repeats
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dacHeld_r <= 16'h0000;
        end else if (sampleTick) begin
            dacHeld_r <= dacIn_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interpolator
    logic signed [35:0] ii1_r, ii2_r, ii3_r, iShift;
    logic stuff_r;
    logic [15:0] interpOut, modIn;
    cdip_comb_if #(.W(19)) intIf ();

    assign intIf.en = sampleTick;
    assign intIf.din = {{3{dacHeld_r[15]}}, dacHeld_r};
    cdip_comb3 u_intComb (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cb(intIf)
    );

    // Zero stuffing: one comb value per period, zeros elsewhere
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stuff_r <= 1'b0;
        end else if (sampleTick) begin
            stuff_r <= 1'b1;
        end else if (bitEn) begin
            stuff_r <= 1'b0;
        end
    end

    // Integrators at the bit rate; N^2 gain removed by the shift
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ii1_r <= '0;
            ii2_r <= '0;
            ii3_r <= '0;
        end else if (bitEn) begin
            ii1_r <= ii1_r + (stuff_r ? {{17{intIf.dout[18]}}, intIf.dout} : 36'sh0);
            ii2_r <= ii2_r + ii1_r;
            ii3_r <= ii3_r + ii2_r;
        end
    end
    assign iShift = ii3_r >>> k2;
    assign interpOut = iShift[15:0];
    assign modIn = bypass_r ? dacHeld_r : interpOut;

    ////////////////////////////////////////////////////////////////////
    // Digital sigma-delta modulator
    logic [17:0] acc_r, acc_nxt, fb;
    logic dacBit_r;

    // First order error feedback; plenty for a single-bit DAC here
    assign fb = dacBit_r ? `CDIP_DSM_FBP : `CDIP_DSM_FBN;
    assign acc_nxt = acc_r + {{2{modIn[15]}}, modIn} - fb;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_r <= 18'h00000;
            dacBit_r <= 1'b0;
        end else if (bitEn) begin
            acc_r <= acc_nxt;
            dacBit_r <= !acc_nxt[17];
        end
    end
    assign dacBit = dacBit_r;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    property p_gain;
        @(posedge sys_clk) disable iff (!rst_n)
        // Table lags the code by one cycle, so the previous code decides
        gainDb == ($past(gainSel) == 3'h0 ? `CDIP_DB0 :
                   $past(gainSel) == 3'h1 ? `CDIP_DB1 :
                   $past(gainSel) == 3'h2 ? `CDIP_DB2 :
                   $past(gainSel) == 3'h3 ? `CDIP_DB3 :
                   $past(gainSel) == 3'h4 ? `CDIP_DB4 :
                   $past(gainSel) == 3'h5 ? `CDIP_DB5 :
                   $past(gainSel) == 3'h6 ? `CDIP_DB6 : `CDIP_DB7);
    endproperty
    a_gain: assert property (p_gain) else $error("gain dB wrong");
    property p_bit;
        @(posedge sys_clk) disable iff (!rst_n)
        bitEn |=> !bitEn [*7] ##1 bitEn;
    endproperty
    a_bit: assert property (p_bit) else $error("bit rate wrong");
    property p_len;
        @(posedge sys_clk) disable iff (!rst_n)
        sampleTick |=> osrCnt_r == 8'h00;
    endproperty
    a_len: assert property (p_len) else $error("period restart wrong");
    property p_lsb;
        @(posedge sys_clk) disable iff (!rst_n)
        // Word was formatted a cycle before the strobe; a rate write may fall between
        adcStrobe && $past(rateSel_r) == CDIP_R64K && !$past(mixed_r) |-> adcWord[1:0] == 2'h0;
    endproperty
    a_lsb: assert property (p_lsb) else $error("low bits not zero");
    property p_mix;
        @(posedge sys_clk) disable iff (!rst_n)
        adcStrobe && $past(mixed_r) |-> adcWord[15] == `CDIP_DATA_FLAG;
    endproperty
    a_mix: assert property (p_mix) else $error("flag bit wrong");
    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        sampleTick && !pend_r && !wrEn |=> dacHeld_r == $past(dacHeld_r);
    endproperty
    a_hold: assert property (p_hold) else $error("held sample lost");
    property p_byp;
        @(posedge sys_clk) disable iff (!rst_n)
        bypass_r |-> modIn == dacHeld_r;
    endproperty
    a_byp: assert property (p_byp) else $error("bypass not taken");
    property p_dsm;
        @(posedge sys_clk) disable iff (!rst_n)
        dacBit != $past(dacBit) |-> $past(bitEn);
    endproperty
    a_dsm: assert property (p_dsm) else $error("bit off rate");
    property p_adc;
        @(posedge sys_clk) disable iff (!rst_n)
        sampleTick |-> ##2 adcStrobe;
    endproperty
    a_adc: assert property (p_adc) else $error("word late");
    c_write: cover property (@(posedge sys_clk) wrEn && addr_r == `CDIP_OFS_DAC);
    c_reuse: cover property (@(posedge sys_clk) sampleTick && !pend_r);
    c_r8k: cover property (@(posedge sys_clk) adcStrobe && rateSel_r == CDIP_R8K);
endmodule
`default_nettype wire

// ==== cdip_mod_src.sv ====
/*
 * Stand-in for the analog modulator that feeds the decimator one bit per bit period.
 * Assumes bitStrobe marks the bit rate and that the bench picks the bit pattern.
 */
`timescale 1ns/100ps
`default_nettype none
module cdip_mod_src (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pattern control from the bench
    input wire logic [1:0] srcMode,
    input wire logic srcRand,
    // Bit rate and stream
    input wire logic bitStrobe,
    output logic modBitPin
);
    ////////////////////////////////////////////////////////////////////////////////
    // Bit changes only on a bit-rate boundary, never faster than the real part
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            modBitPin <= 1'b0;
        end else if (bitStrobe) begin
            modBitPin <= (srcMode == 2'h2) ? srcRand : srcMode[0]; // Mode 2 random
        end
    end
endmodule
`default_nettype wire

// ==== cdip_path_bench.sv ====
/*
 * Self-checking bench for the codec path: bus, gain, ADC words, DAC bit stream.
 * Assumes the modulator stand-in and a zero wait state AHB-Lite slave.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cdip_cfg.svh"
module cdip_path_bench import cdip_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, adcStrobe, dacBit, bitStrobe, modBitPin;
    logic [2:0] gainSel;
    logic [5:0] gainDb;
    logic [15:0] adcWord;
    logic [1:0] srcMode = 2'h0;
    logic srcRand = 1'b0;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and free-running cycle count for period checks
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    cdip_path i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .gainSel(gainSel), .gainDb(gainDb), .modBitPin(modBitPin), .adcWord(adcWord),
        .adcStrobe(adcStrobe), .dacBit(dacBit), .bitStrobe(bitStrobe));

    cdip_mod_src i_src (.sys_clk(sys_clk), .rst_n(rst_n), .srcMode(srcMode),
        .srcRand(srcRand), .bitStrobe(bitStrobe), .modBitPin(modBitPin));

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One single transfer; entered just after a rising edge, leaves on one
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) check("bus wait", 32'h1, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        ahb(1'b1, a, d, v);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0, v);
        check(what, exp, v);
    endtask

    // Bounded wait for the next ADC word; a hang shows as a mismatch
    task automatic waitAdc();
        int n;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (adcStrobe !== 1'b1 && n < 5000);
        if (n >= 5000) check("adcStrobe wait", 32'h1, 32'h0);
    endtask

    // Ones density of the DAC stream over k bit periods
    task automatic countOnes(input int k, output int c);
        int n;
        c = 0;
        repeat (k) begin
            n = 0;
            do begin @(posedge sys_clk); n++; end while (bitStrobe !== 1'b1 && n < 20);
            c += (dacBit === 1'b1) ? 1 : 0;
        end
    endtask

    // Write right after an ADC word so the next sample tick is a full period away
    task automatic dacStep(input logic [15:0] v, output int ones);
        logic [31:0] s;
        int n;
        waitAdc();
        wr(`CDIP_OFS_DAC, {16'h0, v});
        rdChk(`CDIP_OFS_STAT, 32'h1, "dac pending");
        n = 0;
        do begin ahb(1'b0, `CDIP_OFS_STAT, 32'h0, s); n++; end while (s !== 32'h0 && n < 400);
        check("pending cleared", 32'h0, s);
        countOnes(32, ones);
    endtask

    // Gain in dB per select code
    function automatic logic [5:0] expDb(input logic [2:0] c);
        logic [5:0] t [8] = '{6'h00, 6'h06, 6'h0C, 6'h12, 6'h14, 6'h1A, 6'h20, 6'h26};
        return t[c];
    endfunction

    // Steady ADC word for an all-ones or all-zeros stream
    // At 64k the two low bits of the plain word read zero even at full scale; the mixed word shifts right, so only bit 0 does
    function automatic logic [15:0] expAdc(input logic one, input logic mix, input logic r64);
        logic [15:0] t;
        t = one ? 16'h7FFF : 16'h8000;
        if (r64) t[1:0] = 2'h0;
        return mix ? {1'b0, t[15:1]} : t;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog, far above the roughly 51k cycles the tests need
    initial begin
        #(90000 * 10);
        bad_count++;
        $display("[FAIL] run end expected done seen timeout");
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int c, t0, off;
        logic [2:0] g;
        logic [1:0] r;
        logic one, mix;
        logic [31:0] v;
        void'($urandom(37));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check("reset outputs", 32'h0, 32'({gainSel, gainDb, adcWord, dacBit, adcStrobe}));
        check("bus response", 32'h2, {30'h0, hreadyout, hresp});
        rdChk(`CDIP_OFS_RATE, {30'h0, `CDIP_RATE_RST}, "rate reset");
        rdChk(`CDIP_OFS_GAIN, {29'h0, `CDIP_GAIN_RST}, "gain reset");
        // Bit rate is clock over eight with a divide-by-one master divider
        c = 0;
        do begin @(posedge sys_clk); c++; end while (bitStrobe !== 1'b1 && c < 20);
        t0 = cyc;
        c = 0;
        do begin @(posedge sys_clk); c++; end while (bitStrobe !== 1'b1 && c < 20);
        check("bit period", 32'd8, cyc - t0);
        // Every gain code, from a random start
        off = $urandom % 8;
        for (int i = 0; i < 8; i++) begin
            g = 3'(i + off);
            wr(`CDIP_OFS_GAIN, {29'h0, g});
            repeat (2) @(posedge sys_clk);
            check("gainSel", {29'h0, g}, {29'h0, gainSel});
            check("gainDb", {26'h0, expDb(g)}, {26'h0, gainDb});
            rdChk(`CDIP_OFS_GAIN, {29'h0, g}, "gain readback");
        end
        // Unmapped place reads zero and ignores writes
        wr(8'h18, 32'hFFFFFFFF);
        rdChk(8'h18, 32'h0, "unmapped read");
        rdChk(`CDIP_OFS_GAIN, {29'h0, g}, "gain after unmapped write");
        // Every rate, both stream extremes, both word formats
        for (int i = 0; i < 8; i++) begin
            r = 2'(i >> 1);
            one = i[0];
            mix = one ^ r[0];
            wr(`CDIP_OFS_RATE, {30'h0, r});
            rdChk(`CDIP_OFS_RATE, {30'h0, r}, "rate readback");
            wr(`CDIP_OFS_FILT, {31'h0, mix});
            srcMode <= {1'b0, one};
            repeat (4) waitAdc();
            t0 = cyc;
            waitAdc();
            check("word period", 32'(32 << r) * 8, cyc - t0);
            check("adc word", {16'h0, expAdc(one, mix, r == 2'h0)}, {16'h0, adcWord});
            rdChk(`CDIP_OFS_ADC, {16'h0, expAdc(one, mix, r == 2'h0)}, "adc readback");
        end
        // Random stream at 64k: two low word bits stay zero
        wr(`CDIP_OFS_RATE, {30'h0, CDIP_R64K});
        wr(`CDIP_OFS_FILT, 32'h0);
        srcMode <= 2'h2;
        repeat (6 * 256) begin
            @(posedge sys_clk);
            srcRand <= 1'($urandom);
            if (adcStrobe === 1'b1) check("low bits", 32'h0, {30'h0, adcWord[1:0]});
        end
        v = $urandom;
        wr(`CDIP_OFS_DAC, v);
        rdChk(`CDIP_OFS_DAC, {16'h0, v[15:0]}, "dac readback");
        // Bypass: a full-scale step reaches the modulator at once
        wr(`CDIP_OFS_FILT, 32'h20);
        dacStep(16'h8000, c);
        repeat (6) waitAdc();
        dacStep(16'h7FFF, c);
        check("bypass step ones", 32'h1, 32'(c >= 28));
        // No further writes: held sample keeps the stream at full scale
        repeat (3) waitAdc();
        countOnes(64, c);
        check("held sample ones", 32'h1, 32'(c >= 60));
        rdChk(`CDIP_OFS_DAC, 32'h7FFF, "dac held");
        // Interpolator: the step ramps slowly, then settles
        wr(`CDIP_OFS_FILT, 32'h0);
        dacStep(16'h8000, c);
        repeat (6) waitAdc();
        dacStep(16'h7FFF, c);
        check("interp step ones", 32'h1, 32'(c <= 16));
        repeat (4) waitAdc();
        countOnes(64, c);
        check("interp settled ones", 32'h1, 32'(c >= 60));
        dacStep(16'h0000, c);
        repeat (4) waitAdc();
        countOnes(64, c);
        check("mid-scale ones", 32'h1, 32'(c >= 20 && c <= 44));
        end_sim();
    end
endmodule
`default_nettype wire
